// >>> hdl/mcs_return_stack.sv
// Four-deep return address stack
module mcs_return_stack
  import mcs_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire mcs_stk_t op_in,
  input wire logic [UADDR_W-1:0] link_in,
  output logic [UADDR_W-1:0] top_out
);
  typedef struct packed {
    logic [STACK_DEPTH-1:0][UADDR_W-1:0] mem;
    logic [SP_W-1:0] sp;
  } mcs_stk_state_t;

  mcs_stk_state_t s_q, s_d;

  assign top_out = s_q.mem[s_q.sp];

  always_comb begin
    s_d = s_q;
    case (op_in)
      MCS_STK_PUSH: begin
        // Overflow wraps and overwrites the oldest link
        s_d.sp = s_q.sp + 2'h1;
        s_d.mem[s_q.sp + 2'h1] = link_in;
      end
      MCS_STK_POP: begin
        s_d.sp = s_q.sp - 2'h1;
      end
      MCS_STK_LOAD: begin
        s_d.mem[s_q.sp] = link_in;
      end
      default: begin
      end
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
endmodule // mcs_return_stack

// >>> hdl/mcs_sequencer.sv
// Microprogram sequencer with control store pipeline register
//
// What this block does
// - Condition-enable bit picks one of two next-address control sets.
// - Selected test object true uses first set, false uses second.
// - Jump address from map, interrupt buffer, vector or branch field.
// - Instruction start jumps via map; vector disabled, interrupt sampled.
// - Vectored jump: eight microword high bits, four vector low bits.
// - Vector chooses mode bits, variant bits, A operand or autoload.
// - Interrupts are sampled only on a mapped jump.
// - Allowed interrupt forces fixed code plus five-bit vector.
// - Pipeline holds data control bits; sequencing bits feed sequencer.
// - Pipeline and microaddress load on the same edge.
// - Load on rising edge; pipelined word executes next cycle.
// - Next fetch overlaps execution of current microinstruction.
// - One cycle between pipeline loads bounds data element operation.
// - Prefetched instruction goes to holding register during sequence.
// - Address source is repeat, return, next or jump.
// - Four-entry stack with hold, pop, push and load-plus-one.
// - Direct jump uses branch field bits zero to eleven.
// - Return selects stack and pops it in the same cycle.
module mcs_sequencer
  import mcs_pkg::*;
#(
  parameter int CW = CTRL_W
) (
  // Clock and reset
  input wire logic MCLK_IN,
  input wire logic RESET_IN,
  // Control store word, sequencing part
  input wire logic COND_EN_IN,
  input wire logic TEST_IN,
  input wire mcs_src_t SRC_T_IN,
  input wire mcs_stk_t STK_T_IN,
  input wire mcs_src_t SRC_F_IN,
  input wire mcs_stk_t STK_F_IN,
  input wire mcs_jmp_t JMP_SEL_IN,
  input wire mcs_vec_t VEC_SEL_IN,
  input wire logic [BRANCH_W-1:0] BRANCH_IN,
  // Control store word, data manipulation part
  input wire logic [CW-1:0] CTRL_IN,
  // Jump address sources
  input wire logic [UADDR_W-1:0] MAP_ADDR_IN,
  input wire logic INT_PEND_IN,
  input wire logic [IVEC_W-1:0] INT_VEC_IN,
  input wire logic [DATA_W-1:0] INSTRUCTION_REGISTER_IN,
  input wire logic [VEC_LO_W-1:0] A_SOURCE_VECTOR_IN,
  input wire logic [VEC_LO_W-1:0] AUTOLOAD_DESCRIPTOR_IN,
  // Prefetch path
  input wire logic PREFETCH_LOAD_IN,
  input wire logic [DATA_W-1:0] PREFETCH_DATA_IN,
  // Outputs
  output logic [UADDR_W-1:0] UADDR_OUT,
  output logic [CW-1:0] PIPE_CTRL_OUT,
  output logic INT_TAKEN_OUT,
  output logic [DATA_W-1:0] PREFETCH_HOLDING_REG_OUT
);
  typedef struct packed {
    logic [UADDR_W-1:0] uaddr;
    logic [CW-1:0] pipe;
    logic int_taken;
    logic [DATA_W-1:0] prefetch;
  } mcs_state_t;

  mcs_state_t s_q, s_d;
  mcs_src_t src_sel;
  mcs_stk_t stk_sel;
  mcs_stk_t stk_op;
  logic [UADDR_W-1:0] incr;
  logic [UADDR_W-1:0] stack_top;
  logic [UADDR_W-1:0] jump_addr;
  logic [VEC_LO_W-1:0] vec_lo;
  logic is_jump;
  logic map_jump;
  logic int_take;
  logic vec_en;

  // Interrupt entry point: fixed code above the encoded level
  function automatic logic [UADDR_W-1:0] int_entry(
    input logic [IVEC_W-1:0] vec
  );
    return {INT_FIXED_CODE, vec};
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Control set selection
  always_comb begin
    src_sel = SRC_T_IN;
    stk_sel = STK_T_IN;
    if (COND_EN_IN && !TEST_IN) begin
      src_sel = SRC_F_IN;
      stk_sel = STK_F_IN;
    end
  end

  assign incr = s_q.uaddr + 12'h001;
  assign is_jump = (src_sel == MCS_SRC_JUMP);
  assign map_jump = is_jump && (JMP_SEL_IN == MCS_JMP_MAP);
  // Interrupts looked at only during a mapped jump
  assign int_take = map_jump && INT_PEND_IN;
  assign vec_en = is_jump && (JMP_SEL_IN == MCS_JMP_VECTOR);
  // A return always pops, whatever the stack field says
  assign stk_op = (src_sel == MCS_SRC_RETURN) ? MCS_STK_POP : stk_sel;

  ////////////////////////////////////////////////////////////////////////
  // Submodules
  mcs_vector_select u_vec (
    .sel_in(VEC_SEL_IN),
    .instr_in(INSTRUCTION_REGISTER_IN),
    .asrc_in(A_SOURCE_VECTOR_IN),
    .autoload_in(AUTOLOAD_DESCRIPTOR_IN),
    .enable_in(vec_en),
    .vec_out(vec_lo)
  );

  mcs_return_stack u_stk (
    .clk_in(MCLK_IN),
    .rst_in(RESET_IN),
    .op_in(stk_op),
    .link_in(incr),
    .top_out(stack_top)
  );

  ////////////////////////////////////////////////////////////////////////
  // Jump address multiplexer
  always_comb begin
    jump_addr = BRANCH_IN[BRANCH_W-1:0];
    case (JMP_SEL_IN)
      MCS_JMP_MAP: begin
        if (int_take) begin
          jump_addr = int_entry(INT_VEC_IN);
        end else begin
          jump_addr = MAP_ADDR_IN;
        end
      end
      MCS_JMP_VECTOR: begin
        jump_addr = {BRANCH_IN[UADDR_W-1:VEC_LO_W], vec_lo};
      end
      MCS_JMP_INTR: begin
        // Interrupt entry without going through the map
        jump_addr = int_entry(INT_VEC_IN);
      end
      default: begin
        jump_addr = BRANCH_IN;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    s_d = s_q;
    case (src_sel)
      MCS_SRC_REPEAT: begin
        s_d.uaddr = s_q.uaddr;
      end
      MCS_SRC_RETURN: begin
        s_d.uaddr = stack_top;
      end
      MCS_SRC_JUMP: begin
        s_d.uaddr = jump_addr;
      end
      default: begin
        s_d.uaddr = incr;
      end
    endcase
    // Data controls captured alongside the address
    s_d.pipe = CTRL_IN;
    s_d.int_taken = int_take;
    if (PREFETCH_LOAD_IN) begin
      s_d.prefetch = PREFETCH_DATA_IN;
    end
  end

  // Single register stage: fetch of next word overlaps execution
  always_ff @(posedge MCLK_IN) begin
    if (RESET_IN) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // The full cycle is left to data elements; no extra stage here
  assign UADDR_OUT = s_q.uaddr;
  assign PIPE_CTRL_OUT = s_q.pipe;
  assign INT_TAKEN_OUT = s_q.int_taken;
  assign PREFETCH_HOLDING_REG_OUT = s_q.prefetch;

  ////////////////////////////////////////////////////////////////////////
  // Assertions
  a_pipe_tracks_input: assert property (
    @(posedge MCLK_IN) disable iff (RESET_IN)
    !$past(RESET_IN) |-> PIPE_CTRL_OUT == $past(CTRL_IN))
    else $error("pipeline did not capture control bits");

  a_addr_with_pipe: assert property (
    @(posedge MCLK_IN) disable iff (RESET_IN)
    !$past(RESET_IN) |-> UADDR_OUT == $past(s_d.uaddr))
    else $error("address not loaded with pipeline");

  a_next_increments: assert property (
    @(posedge MCLK_IN) disable iff (RESET_IN)
    src_sel == MCS_SRC_NEXT |=> UADDR_OUT == $past(UADDR_OUT) + 12'h001)
    else $error("next did not increment");

  a_repeat_holds: assert property (
    @(posedge MCLK_IN) disable iff (RESET_IN)
    src_sel == MCS_SRC_REPEAT |=> $stable(UADDR_OUT))
    else $error("repeat changed address");

  a_false_uses_second: assert property (
    @(posedge MCLK_IN) disable iff (RESET_IN)
    COND_EN_IN && !TEST_IN |-> src_sel == SRC_F_IN && stk_sel == STK_F_IN)
    else $error("false test did not use second set");

  a_true_uses_first: assert property (
    @(posedge MCLK_IN) disable iff (RESET_IN)
    COND_EN_IN && TEST_IN |-> src_sel == SRC_T_IN && stk_sel == STK_T_IN)
    else $error("true test did not use first set");

  a_uncond_first_set: assert property (
    @(posedge MCLK_IN) disable iff (RESET_IN)
    !COND_EN_IN |-> src_sel == SRC_T_IN && stk_sel == STK_T_IN)
    else $error("unconditional word used second set");

  a_int_only_mapped: assert property (
    @(posedge MCLK_IN) disable iff (RESET_IN)
    INT_TAKEN_OUT |-> $past(map_jump) && $past(INT_PEND_IN))
    else $error("interrupt taken outside mapped jump");

  a_int_vector_addr: assert property (
    @(posedge MCLK_IN) disable iff (RESET_IN)
    int_take |=> UADDR_OUT == {INT_FIXED_CODE, $past(INT_VEC_IN)})
    else $error("interrupt address wrong");

  a_vector_addr: assert property (
    @(posedge MCLK_IN) disable iff (RESET_IN)
    vec_en |=> UADDR_OUT[UADDR_W-1:VEC_LO_W] ==
      $past(BRANCH_IN[UADDR_W-1:VEC_LO_W]))
    else $error("vector high bits wrong");

  a_vector_asrc: assert property (
    @(posedge MCLK_IN) disable iff (RESET_IN)
    vec_en && VEC_SEL_IN == MCS_VEC_ASRC |=>
      UADDR_OUT[VEC_LO_W-1:0] == $past(A_SOURCE_VECTOR_IN))
    else $error("vector low bits not from A operand");

  a_vector_idle: assert property (
    @(posedge MCLK_IN) disable iff (RESET_IN)
    !vec_en |-> vec_lo == '0)
    else $error("vector selector active outside vector jump");

  a_field_jump: assert property (
    @(posedge MCLK_IN) disable iff (RESET_IN)
    is_jump && JMP_SEL_IN == MCS_JMP_FIELD |=>
      UADDR_OUT == $past(BRANCH_IN))
    else $error("direct jump not taken from branch field");

  a_direct_intr: assert property (
    @(posedge MCLK_IN) disable iff (RESET_IN)
    is_jump && JMP_SEL_IN == MCS_JMP_INTR |=>
      UADDR_OUT == {INT_FIXED_CODE, $past(INT_VEC_IN)} && !INT_TAKEN_OUT)
    else $error("direct interrupt jump wrong");

  a_map_addr: assert property (
    @(posedge MCLK_IN) disable iff (RESET_IN)
    map_jump && !INT_PEND_IN |=> UADDR_OUT == $past(MAP_ADDR_IN))
    else $error("mapped jump address wrong");

  a_return_to_link: assert property (
    @(posedge MCLK_IN) disable iff (RESET_IN)
    src_sel == MCS_SRC_RETURN |=> UADDR_OUT == $past(stack_top))
    else $error("return address wrong");

  a_return_pops: assert property (
    @(posedge MCLK_IN) disable iff (RESET_IN)
    src_sel == MCS_SRC_RETURN |-> stk_op == MCS_STK_POP)
    else $error("return did not pop the stack");

  a_int_flag_set: assert property (
    @(posedge MCLK_IN) disable iff (RESET_IN)
    int_take |=> INT_TAKEN_OUT)
    else $error("interrupt entry not flagged");

  a_prefetch_load: assert property (
    @(posedge MCLK_IN) disable iff (RESET_IN)
    PREFETCH_LOAD_IN |=>
      PREFETCH_HOLDING_REG_OUT == $past(PREFETCH_DATA_IN))
    else $error("prefetched word not held");

  a_prefetch_holds: assert property (
    @(posedge MCLK_IN) disable iff (RESET_IN)
    !PREFETCH_LOAD_IN |=> $stable(PREFETCH_HOLDING_REG_OUT))
    else $error("holding register changed without load");

  a_reset_clears: assert property (
    @(posedge MCLK_IN)
    RESET_IN |=> UADDR_OUT == UADDR_RESET && PIPE_CTRL_OUT == CTRL_RESET &&
      !INT_TAKEN_OUT)
    else $error("reset did not clear state");
endmodule // mcs_sequencer

// >>> hdl/mcs_vector_select.sv
// Four-way vector selector for the low jump address bits
module mcs_vector_select
  import mcs_pkg::*;
(
  input wire mcs_vec_t sel_in,
  input wire logic [DATA_W-1:0] instr_in,
  input wire logic [VEC_LO_W-1:0] asrc_in,
  input wire logic [VEC_LO_W-1:0] autoload_in,
  input wire logic enable_in,
  output logic [VEC_LO_W-1:0] vec_out
);
  always_comb begin
    vec_out = '0;
    if (enable_in) begin
      case (sel_in)
        MCS_VEC_MODE: begin
          vec_out = {1'b0, instr_in[INSTR_MODE_HI:INSTR_MODE_LO]};
        end
        MCS_VEC_VARIANT: begin
          vec_out = instr_in[INSTR_VAR_HI:INSTR_VAR_LO];
        end
        MCS_VEC_ASRC: begin
          vec_out = asrc_in;
        end
        default: begin
          vec_out = autoload_in;
        end
      endcase
    end
  end
endmodule // mcs_vector_select

// >>> inc/mcs_pkg.sv
// Shared constants and types for the microcode sequencer pipeline
package mcs_pkg;
  localparam int UADDR_W = 12;
  localparam int BRANCH_W = 12;
  localparam int VEC_HI_W = 8;
  localparam int VEC_LO_W = 4;
  localparam int IVEC_W = 5;
  localparam int STACK_DEPTH = 4;
  localparam int SP_W = 2;
  localparam int DATA_W = 16;
  localparam int CTRL_W = 32;
  // Upper bits of interrupt entry; arbitrary placement
  localparam logic [6:0] INT_FIXED_CODE = 7'h7F;
  localparam logic [UADDR_W-1:0] UADDR_RESET = 12'h000;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 32'h0000_0000;
  localparam int INSTR_MODE_LO = 8;
  localparam int INSTR_MODE_HI = 10;
  localparam int INSTR_VAR_LO = 0;
  localparam int INSTR_VAR_HI = 3;

  typedef enum logic [1:0] {
    MCS_SRC_NEXT = 2'b00,
    MCS_SRC_REPEAT = 2'b01,
    MCS_SRC_JUMP = 2'b11,
    MCS_SRC_RETURN = 2'b10
  } mcs_src_t;

  typedef enum logic [1:0] {
    MCS_STK_HOLD = 2'b00,
    MCS_STK_POP = 2'b01,
    MCS_STK_PUSH = 2'b11,
    MCS_STK_LOAD = 2'b10
  } mcs_stk_t;

  // Jump address origin
  typedef enum logic [1:0] {
    MCS_JMP_FIELD = 2'b00,
    MCS_JMP_MAP = 2'b01,
    MCS_JMP_VECTOR = 2'b11,
    MCS_JMP_INTR = 2'b10
  } mcs_jmp_t;

  typedef enum logic [1:0] {
    MCS_VEC_MODE = 2'b00,
    MCS_VEC_VARIANT = 2'b01,
    MCS_VEC_ASRC = 2'b11,
    MCS_VEC_AUTOLOAD = 2'b10
  } mcs_vec_t;
endpackage : mcs_pkg

// >>> tb/mcs_store.sv
// Behavioural microprogram control store for the sequencer bench
module mcs_store
  import mcs_pkg::*;
(
  // Address from the sequencer
  input wire logic [UADDR_W-1:0] ua_in,
  // Sequencing part of the word
  output logic cen_out,
  output mcs_src_t srt_out,
  output mcs_stk_t stt_out,
  output mcs_src_t srf_out,
  output mcs_stk_t stf_out,
  output mcs_jmp_t jmp_out,
  output mcs_vec_t vec_out,
  output logic [BRANCH_W-1:0] br_out,
  // Data manipulation part
  output logic [CTRL_W-1:0] ctl_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [24:0] rom [0:4095];
  logic [24:0] w;
  // Zero-delay read: fetch of next word overlaps current execution
  // Continuous read, so a word written under a steady address shows at once
  assign w = rom[ua_in];
  always_comb begin
    cen_out = w[24];
    srt_out = mcs_src_t'(w[23:22]);
    stt_out = mcs_stk_t'(w[21:20]);
    srf_out = mcs_src_t'(w[19:18]);
    stf_out = mcs_stk_t'(w[17:16]);
    jmp_out = mcs_jmp_t'(w[15:14]);
    vec_out = mcs_vec_t'(w[13:12]);
    br_out = w[11:0];
    // Control bits carry their own address so the pipeline is traceable
    ctl_out = {20'h5A5A5, ua_in};
  end
endmodule // mcs_store

// >>> tb/tb.sv
// Self-checking bench for the microcode sequencer pipeline
module tb
  import mcs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic test = 1'b0;
  logic [11:0] map = 12'h000;
  logic ipend = 1'b0;
  logic [4:0] ivec = 5'h13;
  logic [15:0] instr = 16'h0A5C;
  logic [3:0] av = 4'h9;
  logic [3:0] autoload = 4'h6;
  logic pf_ld = 1'b0;
  logic [15:0] pf_d = 16'h0000;
  logic cen;
  mcs_src_t srt, srf;
  mcs_stk_t stt, stf;
  mcs_jmp_t js;
  mcs_vec_t vs;
  logic [11:0] br, ua;
  logic [31:0] ctl, pc;
  logic it;
  logic [15:0] ph;
  int errors = 0;
  int checks = 0;
  always #50 clk = ~clk;
  mcs_store i_store (.ua_in(ua), .cen_out(cen), .srt_out(srt),
    .stt_out(stt), .srf_out(srf), .stf_out(stf), .jmp_out(js),
    .vec_out(vs), .br_out(br), .ctl_out(ctl));
  mcs_sequencer i_dut (.MCLK_IN(clk), .RESET_IN(rst), .COND_EN_IN(cen),
    .TEST_IN(test), .SRC_T_IN(srt), .STK_T_IN(stt), .SRC_F_IN(srf),
    .STK_F_IN(stf), .JMP_SEL_IN(js), .VEC_SEL_IN(vs), .BRANCH_IN(br),
    .CTRL_IN(ctl), .MAP_ADDR_IN(map), .INT_PEND_IN(ipend),
    .INT_VEC_IN(ivec), .INSTRUCTION_REGISTER_IN(instr),
    .A_SOURCE_VECTOR_IN(av), .AUTOLOAD_DESCRIPTOR_IN(autoload),
    .PREFETCH_LOAD_IN(pf_ld), .PREFETCH_DATA_IN(pf_d), .UADDR_OUT(ua),
    .PIPE_CTRL_OUT(pc), .INT_TAKEN_OUT(it),
    .PREFETCH_HOLDING_REG_OUT(ph));
  ////////////////////////////////////////////////////////////////////////
  function automatic logic [24:0] w(logic c, logic [1:0] s1, logic [1:0] k1,
    logic [1:0] s2, logic [1:0] k2, logic [1:0] j, logic [1:0] v,
    logic [11:0] b);
    return {c, s1, k1, s2, k2, j, v, b};
  endfunction
  task automatic check(string n, logic [31:0] seen, logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      $display("[FAIL] %s expected %h seen %h", n, exp, seen);
      errors++;
    end
  endtask
  // Edge, then settle to the falling edge where inputs change
  task automatic step();
    @(posedge clk);
    @(negedge clk);
  endtask
  // Fresh store and sequencer at address zero for every scenario but t_pref
  // Extra falling edge keeps reset from toggling twice in one time step
  task automatic reset_all();
    @(negedge clk);
    for (int i = 0; i < 4096; i++) i_store.rom[i] = 25'h0;
    rst = 1'b1;
    repeat (3) step();
    rst = 1'b0;
  endtask
  task automatic close_out();
    if (errors == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    pf_ld = 1'b1;
    pf_d = 16'hBEEF;
    reset_all();
    pf_ld = 1'b0;
    check("uaddr", ua, 12'h000);
    check("pipe", pc, 32'h0);
    check("int", it, 1'b0);
    check("hold", ph, 16'h0);
  endtask
  task automatic t_map();
    reset_all();
    i_store.rom[0] = w(0, MCS_SRC_JUMP, 0, 0, 0, MCS_JMP_MAP, 0, 12'h3A5);
    map = 12'h055;
    step();
    check("map", ua, 12'h055);
    check("pipe", pc, 32'h5A5A5000);
    step();
    check("next", ua, 12'h056);
    check("pipe", pc, 32'h5A5A5055);
  endtask
  task automatic t_cond();
    for (int t = 0; t < 2; t++) begin
      reset_all();
      i_store.rom[0] = w(1, MCS_SRC_JUMP, 0, 0, 0, 0, 0, 12'hABC);
      test = t[0];
      step();
      check("cond", ua, t ? 12'hABC : 12'h001);
    end
  endtask
  task automatic t_vec();
    logic [1:0] sel [4] = '{MCS_VEC_MODE, MCS_VEC_VARIANT, MCS_VEC_ASRC,
      MCS_VEC_AUTOLOAD};
    logic [3:0] exp [4] = '{4'h2, 4'hC, 4'h9, 4'h6};
    for (int i = 0; i < 4; i++) begin
      reset_all();
      i_store.rom[0] = w(0, MCS_SRC_JUMP, 0, 0, 0, MCS_JMP_VECTOR, sel[i],
        12'h3A5);
      step();
      check("vector", ua, {8'h3A, exp[i]});
    end
  endtask
  task automatic t_int();
    reset_all();
    ipend = 1'b1;
    i_store.rom[0] = w(0, MCS_SRC_JUMP, 0, 0, 0, 0, 0, 12'h123);
    i_store.rom[12'h123] = w(0, MCS_SRC_JUMP, 0, 0, 0, MCS_JMP_MAP, 0, 0);
    step();
    check("field", ua, 12'h123);
    check("int", it, 1'b0);
    step();
    check("intaddr", ua, 12'hFF3);
    check("int", it, 1'b1);
    step();
    ipend = 1'b0;
    check("after", ua, 12'hFF4);
    check("int", it, 1'b0);
    i_store.rom[12'hFF4] = w(0, MCS_SRC_JUMP, 0, 0, 0, MCS_JMP_INTR, 0, 0);
    step();
    check("direct", ua, 12'hFF3);
    check("int", it, 1'b0);
  endtask
  task automatic t_sub();
    reset_all();
    i_store.rom[0] = w(0, 0, MCS_STK_LOAD, 0, 0, 0, 0, 0);
    i_store.rom[1] = w(0, MCS_SRC_RETURN, 0, 0, 0, 0, 0, 0);
    step();
    step();
    check("load", ua, 12'h001);
    reset_all();
    i_store.rom[0] = w(0, MCS_SRC_JUMP, MCS_STK_PUSH, 0, 0, 0, 0, 12'h200);
    i_store.rom[12'h200] = w(1, MCS_SRC_REPEAT, 0, MCS_SRC_RETURN, 0, 0,
      0, 0);
    i_store.rom[1] = w(0, MCS_SRC_RETURN, 0, 0, 0, 0, 0, 0);
    test = 1'b1;
    step();
    step();
    check("repeat", ua, 12'h200);
    test = 1'b0;
    step();
    check("return", ua, 12'h001);
    step();
    check("popped", ua, 12'h000);
  endtask
  task automatic t_pref();
    pf_ld = 1'b1;
    pf_d = 16'hBEEF;
    step();
    pf_ld = 1'b0;
    pf_d = 16'h1234;
    check("hold", ph, 16'hBEEF);
    step();
    check("hold", ph, 16'hBEEF);
  endtask
  initial begin
    t_reset();
    t_map();
    t_cond();
    t_vec();
    t_int();
    t_sub();
    t_pref();
    close_out();
  end
endmodule // tb
